// file: verilog/cts_params.svh
// Purpose: constants of the coupler tune sequencer
// Assumes: a 200 MHz system clock
// Notes: times are kept in milliseconds, cycle counts are derived from them
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH

// clock rate in kHz, so that ms * kHz gives cycles
`define CTS_CLK_KHZ 64'd200000
`define CTS_MS_TO_CYC(ms) ((ms) * `CTS_CLK_KHZ)

// documented intervals
`define CTS_HANG_MS 64'd1000
`define CTS_VSWR_OK_MS 64'd300
`define CTS_VSWR_BAD_MS 64'd2000
// intervals of our own
`define CTS_TUNE_TO_MS 64'd10000
`define CTS_BEEP_HALF_MS 64'd250
`define CTS_DEBOUNCE_MS 64'd5

// register port
`define CTS_ADDR_W 4
`define CTS_DATA_W 16
`define CTS_REG_CTRL 4'h0
`define CTS_REG_STATUS 4'h4
`define CTS_REG_FREQ 4'h8
`define CTS_CTRL_RST 16'h0000
`define CTS_CTRL_CW_BIT 0

// status fields
`define CTS_ST_STATE_LSB 0
`define CTS_ST_FAULT_BIT 3
`define CTS_ST_TX_BIT 4
`define CTS_ST_HANG_BIT 5
`define CTS_ST_BAND_LSB 6

`endif

// file: verilog/cts_pkg.sv
// Purpose: shared types of the coupler tune sequencer
// Assumes: nothing
// Notes: constants live in cts_params.svh
package cts_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      CTS_BANDSW,
      CTS_STANDBY,
      CTS_TUNE,
      CTS_OPERATE,
      CTS_RETUNE,
      CTS_FAULT
   } cts_state_e;
   // band number driven to the bandswitch
   typedef logic [2:0] cts_band_t;
endpackage

// file: verilog/cts_tmr_if.sv
// Purpose: condition and expiry pair between sequencer and a timer
// Assumes: both ends on the same clock
// Notes: done is a level while the condition has held long enough
`timescale 1ns/1ps
`default_nettype none
interface cts_tmr_if;
   logic cond; // qualifying condition holds
   logic done; // condition held for the full interval
   modport owner (output cond, input done);
   modport timer (input cond, output done);
endinterface
`default_nettype wire

// file: verilog/cts_debounce.sv
// Purpose: synchronise and debounce one switch line
// Assumes: raw may bounce for less than STABLE_CYC cycles
// Notes: output changes only after the line has been stable
`timescale 1ns/1ps
`default_nettype none
module cts_debounce #(
   parameter int unsigned STABLE_CYC = 1000,
   parameter bit RST_LEVEL = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic raw,
   output logic clean
);
   localparam int W = $clog2(STABLE_CYC + 1);
   logic sync1_ff, sync2_ff; // two-stage synchroniser
   logic [W-1:0] cnt_ff, nxt_cnt; // stable-time counter
   logic clean_ff, nxt_clean; // filtered level

   // restart the count whenever the line agrees with the output
   always_comb begin
      nxt_cnt = '0;
      nxt_clean = clean_ff;
      if (sync2_ff != clean_ff) begin
         if (cnt_ff == W'(STABLE_CYC - 1)) begin
            nxt_clean = sync2_ff;
         end else begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end

   // registers only; first stage feeds the second and nothing else
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_ff <= RST_LEVEL;
         sync2_ff <= RST_LEVEL;
         cnt_ff <= '0;
         clean_ff <= RST_LEVEL;
      end else begin
         sync1_ff <= raw;
         sync2_ff <= sync1_ff;
         cnt_ff <= nxt_cnt;
         clean_ff <= nxt_clean;
      end
   end

   assign clean = clean_ff;

   // output never moves while the synchronised line agrees with it
   a_deb_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (sync2_ff == clean_ff) |=> $stable(clean_ff))
      else $error("debounced level moved without cause");
endmodule
`default_nettype wire

// file: verilog/cts_qual_timer.sv
// Purpose: interval timer that runs while a condition holds
// Assumes: LIMIT of one or more cycles
// Notes: count restarts at zero as soon as the condition lapses
`timescale 1ns/1ps
`default_nettype none
module cts_qual_timer #(
   parameter int unsigned LIMIT = 100
) (
   input wire logic clk,
   input wire logic reset_n,
   cts_tmr_if.timer tif
);
   localparam int W = $clog2(LIMIT + 1);
   logic [W-1:0] cnt_ff, nxt_cnt; // cycles the condition has held

   always_comb begin
      nxt_cnt = '0;
      if (tif.cond) begin
         nxt_cnt = (cnt_ff == W'(LIMIT)) ? cnt_ff : cnt_ff + 1'b1;
      end
   end

   // saturating count register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // expiry is a level while the condition keeps holding
   assign tif.done = (cnt_ff == W'(LIMIT)) && tif.cond;

   a_timer_restart: assert property (@(posedge clk) disable iff (!reset_n)
      !tif.cond |=> (cnt_ff == '0))
      else $error("timer did not restart on lapse");
endmodule
`default_nettype wire

// file: verilog/cts_sequencer.sv
// Purpose: keying, rechannel and coupler tune sequencing
// Assumes: key, ptt and rechannel lines are active low (ground = closed)
// Notes: long intervals are top parameters so simulation can shorten them
//
// Added by the designer: the register offsets and the plain strobed port.
`include "cts_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cts_sequencer #(
   parameter int unsigned HANG_CYC = 32'(`CTS_MS_TO_CYC(`CTS_HANG_MS)),
   parameter int unsigned VSWR_OK_CYC =
      32'(`CTS_MS_TO_CYC(`CTS_VSWR_OK_MS)),
   parameter int unsigned VSWR_BAD_CYC =
      32'(`CTS_MS_TO_CYC(`CTS_VSWR_BAD_MS)),
   parameter int unsigned TUNE_TO_CYC =
      32'(`CTS_MS_TO_CYC(`CTS_TUNE_TO_MS)),
   parameter int unsigned BEEP_HALF_CYC =
      32'(`CTS_MS_TO_CYC(`CTS_BEEP_HALF_MS)),
   parameter int unsigned DEBOUNCE_CYC =
      32'(`CTS_MS_TO_CYC(`CTS_DEBOUNCE_MS))
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ptt_n,
   input wire logic cw_key_n,
   input wire logic rechannel_request_n,
   input wire logic [23:0] freq_bcd,
   input wire logic mode_line,
   input wire logic power_line,
   input wire logic synth_locked,
   input wire logic bandswitch_done,
   input wire logic vswr_high,
   input wire logic tune_overvolt,
   input wire logic synth_tone,
   input wire logic [`CTS_ADDR_W-1:0] reg_addr,
   input wire logic [`CTS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`CTS_DATA_W-1:0] reg_rdata,
   output logic transmit_key,
   output logic tx_path_enable,
   output logic receive_enable,
   output logic modulator_tone,
   output logic headset_tone,
   output logic servo_enable,
   output logic synth_rechannel,
   output logic coupler_rechannel,
   output logic [2:0] band_select,
   output logic fault,
   output logic am_select,
   output logic usb_select,
   output logic high_power_select,
   output logic low_power_select
);
   // lower band edges in MHz; band number counts edges passed
   localparam int NB = 7;
   localparam logic [7:0] BAND_EDGE [NB] =
      '{8'h03, 8'h04, 8'h06, 8'h08, 8'h0b, 8'h0f, 8'h15};

   logic ptt_cl_n, key_cl_n, rech_cl_n;
   cts_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .RST_LEVEL(1'b1)) u_deb_ptt (
      .clk(clk), .reset_n(reset_n), .raw(ptt_n), .clean(ptt_cl_n));
   cts_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .RST_LEVEL(1'b1)) u_deb_key (
      .clk(clk), .reset_n(reset_n), .raw(cw_key_n), .clean(key_cl_n));
   cts_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .RST_LEVEL(1'b1)) u_deb_rch (
      .clk(clk), .reset_n(reset_n), .raw(rechannel_request_n),
      .clean(rech_cl_n));

   // interval timers
   cts_tmr_if hang_if ();
   cts_tmr_if ok_if ();
   cts_tmr_if bad_if ();
   cts_tmr_if to_if ();
   cts_qual_timer #(.LIMIT(HANG_CYC)) u_hang (
      .clk(clk), .reset_n(reset_n), .tif(hang_if));
   cts_qual_timer #(.LIMIT(VSWR_OK_CYC)) u_vswr_ok (
      .clk(clk), .reset_n(reset_n), .tif(ok_if));
   cts_qual_timer #(.LIMIT(VSWR_BAD_CYC)) u_vswr_bad (
      .clk(clk), .reset_n(reset_n), .tif(bad_if));
   cts_qual_timer #(.LIMIT(TUNE_TO_CYC)) u_tune_to (
      .clk(clk), .reset_n(reset_n), .tif(to_if));

   logic ptt, key, keyed; // closed-line levels
   logic rech_prev_ff, press_prev_ff; // edge history
   logic rech_pulse, press; // one-cycle events
   cts_pkg::cts_state_e state_ff, nxt_state;
   logic hang_ff, nxt_hang; // cw hang interval running
   logic [`CTS_DATA_W-1:0] ctrl_ff, nxt_ctrl; // software control
   logic cw_mode; // cw operation selected
   logic [7:0] mhz; // binary MHz from bcd
   cts_pkg::cts_band_t band; // decoded band
   logic [NB-1:0] above; // edge passed, per band edge

   assign ptt = !ptt_cl_n;
   assign key = !key_cl_n;
   assign keyed = ptt || key;
   assign cw_mode = ctrl_ff[`CTS_CTRL_CW_BIT];
   assign rech_pulse = !rech_cl_n && rech_prev_ff;
   assign press = keyed && !press_prev_ff;

   // decode bcd tens and units of MHz, compare per band edge
   assign mhz = (8'(freq_bcd[23:20]) * 8'd10) + 8'(freq_bcd[19:16]);
   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++) begin : g_edge
         assign above[gi] = (mhz >= BAND_EDGE[gi]);
      end
   endgenerate
   always_comb begin
      band = '0;
      for (int i = 0; i < NB; i++) begin
         band = band + 3'(above[i]);
      end
   end

   // timer conditions
   always_comb begin
      // hang counts only while key open
      hang_if.cond = hang_ff && !key;
      ok_if.cond = ((state_ff == cts_pkg::CTS_TUNE) ||
                    (state_ff == cts_pkg::CTS_RETUNE)) && !vswr_high;
      bad_if.cond = (state_ff == cts_pkg::CTS_OPERATE) &&
                    transmit_key && vswr_high;
      // tune cycle that runs too long
      to_if.cond = (state_ff == cts_pkg::CTS_TUNE) ||
                   (state_ff == cts_pkg::CTS_RETUNE);
   end

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         cts_pkg::CTS_BANDSW: begin
            // standby once bandswitch and synth settle
            if (bandswitch_done && synth_locked) begin
               nxt_state = cts_pkg::CTS_STANDBY;
            end
         end
         cts_pkg::CTS_STANDBY: begin
            if (press) begin
               nxt_state = cts_pkg::CTS_TUNE;
            end
         end
         cts_pkg::CTS_TUNE, cts_pkg::CTS_RETUNE: begin
            if (tune_overvolt || to_if.done) begin
               nxt_state = cts_pkg::CTS_FAULT;
            end else if (ok_if.done) begin
               nxt_state = cts_pkg::CTS_OPERATE;
            end
         end
         cts_pkg::CTS_OPERATE: begin
            if (tune_overvolt) begin
               nxt_state = cts_pkg::CTS_FAULT;
            end else if (bad_if.done) begin
               nxt_state = cts_pkg::CTS_RETUNE;
            end
         end
         cts_pkg::CTS_FAULT: nxt_state = cts_pkg::CTS_FAULT;
         default: nxt_state = cts_pkg::CTS_BANDSW;
      endcase
      if (rech_pulse) begin
         nxt_state = cts_pkg::CTS_BANDSW;
      end
   end

   // hang: armed by key in cw mode, ended by timer or by leaving cw mode
   always_comb begin
      nxt_hang = hang_ff;
      if (key && cw_mode) begin
         nxt_hang = 1'b1;
      end else if (hang_if.done || !cw_mode) begin
         nxt_hang = 1'b0;
      end
   end

   // control register write; status is read only
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (reg_wr && (reg_addr == `CTS_REG_CTRL)) begin
         nxt_ctrl = reg_wdata;
      end
   end

   // output values, computed from present state
   logic nxt_tx, nxt_path, nxt_servo, nxt_hs_tone, nxt_mod_tone;
   logic beep_ff, nxt_beep; // beep on/off phase
   logic [31:0] beep_cnt_ff, nxt_beep_cnt; // beep phase timer
   logic [`CTS_DATA_W-1:0] nxt_rdata;
   always_comb begin
      nxt_tx = 1'b0;
      nxt_path = 1'b0;
      nxt_servo = 1'b0;
      nxt_hs_tone = 1'b0;
      case (state_ff)
         cts_pkg::CTS_TUNE: begin
            nxt_tx = 1'b1;
            nxt_path = 1'b1;
            nxt_servo = 1'b1;
            nxt_hs_tone = synth_tone;
         end
         cts_pkg::CTS_OPERATE, cts_pkg::CTS_RETUNE: begin
            // keying follows the lines plus hang
            nxt_tx = keyed || hang_ff;
            nxt_path = 1'b1;
            nxt_servo = (state_ff == cts_pkg::CTS_RETUNE);
         end
         cts_pkg::CTS_FAULT: begin
            nxt_hs_tone = synth_tone && beep_ff;
         end
         default: nxt_tx = 1'b0;
      endcase
      // cw tone to modulator while key closed
      nxt_mod_tone = cw_mode && key && nxt_tx && synth_tone;
   end

   // beep cadence, runs only in fault
   always_comb begin
      nxt_beep = 1'b0;
      nxt_beep_cnt = '0;
      if (state_ff == cts_pkg::CTS_FAULT) begin
         nxt_beep = beep_ff;
         nxt_beep_cnt = beep_cnt_ff + 32'd1;
         if (beep_cnt_ff >= BEEP_HALF_CYC - 1) begin
            nxt_beep_cnt = '0;
            nxt_beep = !beep_ff;
         end
      end
   end

   // read data; unmapped addresses read zero
   always_comb begin
      nxt_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `CTS_REG_CTRL: nxt_rdata = ctrl_ff;
            `CTS_REG_STATUS: begin
               nxt_rdata[`CTS_ST_STATE_LSB +: 3] = state_ff;
               nxt_rdata[`CTS_ST_FAULT_BIT] = fault;
               nxt_rdata[`CTS_ST_TX_BIT] = transmit_key;
               nxt_rdata[`CTS_ST_HANG_BIT] = hang_ff;
               nxt_rdata[`CTS_ST_BAND_LSB +: 3] = band_select;
            end
            `CTS_REG_FREQ: nxt_rdata = freq_bcd[23:8];
            default: nxt_rdata = '0;
         endcase
      end
   end

   // all state and outputs registered here
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= cts_pkg::CTS_BANDSW;
         rech_prev_ff <= 1'b1;
         press_prev_ff <= 1'b0;
         hang_ff <= 1'b0;
         ctrl_ff <= `CTS_CTRL_RST;
         beep_ff <= 1'b0;
         beep_cnt_ff <= '0;
         reg_rdata <= '0;
         transmit_key <= 1'b0;
         tx_path_enable <= 1'b0;
         receive_enable <= 1'b0;
         modulator_tone <= 1'b0;
         headset_tone <= 1'b0;
         servo_enable <= 1'b0;
         synth_rechannel <= 1'b0;
         coupler_rechannel <= 1'b0;
         band_select <= '0;
         fault <= 1'b0;
         am_select <= 1'b0;
         usb_select <= 1'b0;
         high_power_select <= 1'b0;
         low_power_select <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rech_prev_ff <= rech_cl_n;
         press_prev_ff <= keyed;
         hang_ff <= nxt_hang;
         ctrl_ff <= nxt_ctrl;
         beep_ff <= nxt_beep;
         beep_cnt_ff <= nxt_beep_cnt;
         reg_rdata <= nxt_rdata;
         transmit_key <= nxt_tx;
         tx_path_enable <= nxt_path;
         receive_enable <= !nxt_tx;
         modulator_tone <= nxt_mod_tone;
         headset_tone <= nxt_hs_tone;
         servo_enable <= nxt_servo;
         synth_rechannel <= rech_pulse;
         coupler_rechannel <= rech_pulse;
         band_select <= band;
         fault <= (state_ff == cts_pkg::CTS_FAULT);
         am_select <= !mode_line;
         usb_select <= mode_line;
         low_power_select <= !power_line;
         high_power_select <= power_line;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_ptt_keys: assert property (
      (state_ff == cts_pkg::CTS_OPERATE) && ptt |=> transmit_key)
      else $error("ptt closed but not keyed");
   a_open_rx: assert property (
      (state_ff == cts_pkg::CTS_OPERATE) && !keyed && !hang_ff
      |=> receive_enable && !transmit_key)
      else $error("lines open but not receiving");
   a_hang_ends: assert property (
      hang_if.done && !key |=> !hang_ff)
      else $error("hang outlived its interval");
   a_cw_tone: assert property (
      modulator_tone |-> $past(cw_mode && key))
      else $error("modulator tone without cw key");
   a_rech_fwd: assert property (
      rech_pulse |=> synth_rechannel && coupler_rechannel &&
      (state_ff == cts_pkg::CTS_BANDSW))
      else $error("rechannel not forwarded");
   a_bandsw_quiet: assert property (
      (state_ff == cts_pkg::CTS_BANDSW) |=> !tx_path_enable && !transmit_key)
      else $error("transmit during bandswitch");
   a_press_tune: assert property (
      (state_ff == cts_pkg::CTS_STANDBY) && press && !rech_pulse
      |=> (state_ff == cts_pkg::CTS_TUNE))
      else $error("press did not start tune");
   a_tune_key: assert property (
      (state_ff == cts_pkg::CTS_TUNE) |=> transmit_key && servo_enable)
      else $error("tune state not keyed");
   a_tune_done: assert property (
      (state_ff == cts_pkg::CTS_TUNE) && ok_if.done && !tune_overvolt &&
      !to_if.done && !rech_pulse |=> (state_ff == cts_pkg::CTS_OPERATE))
      else $error("tune did not complete");
   a_retune_go: assert property (
      bad_if.done && !tune_overvolt && !rech_pulse
      |=> (state_ff == cts_pkg::CTS_RETUNE))
      else $error("retune not started");
   a_ov_fault: assert property (
      tune_overvolt && !rech_pulse && (state_ff != cts_pkg::CTS_BANDSW) &&
      (state_ff != cts_pkg::CTS_STANDBY)
      |=> (state_ff == cts_pkg::CTS_FAULT) ##1 fault)
      else $error("overvoltage did not fault");
   a_fault_quiet: assert property (
      (state_ff == cts_pkg::CTS_FAULT) |=> !tx_path_enable && !servo_enable)
      else $error("fault left transmit or servo on");
   a_fault_hold: assert property (
      (state_ff == cts_pkg::CTS_FAULT) && !rech_pulse
      |=> (state_ff == cts_pkg::CTS_FAULT))
      else $error("fault cleared without rechannel");
   // outputs follow the switches from the first edge after reset
   a_mode_dec: assert property (
      $past(reset_n) |=> (am_select == !$past(mode_line)) &&
      (usb_select != am_select))
      else $error("mode decode wrong");
   a_power_dec: assert property (
      $past(reset_n) |=> (high_power_select == $past(power_line)) &&
      (low_power_select != high_power_select))
      else $error("power decode wrong");

   c_tune_done: cover property (
      (state_ff == cts_pkg::CTS_TUNE) ##1 (state_ff == cts_pkg::CTS_OPERATE));
   c_retune: cover property ((state_ff == cts_pkg::CTS_RETUNE));
   c_fault_clear: cover property (
      (state_ff == cts_pkg::CTS_FAULT) ##1 (state_ff == cts_pkg::CTS_BANDSW));
   c_cw_hang: cover property (hang_ff && !key && transmit_key);
endmodule
`default_nettype wire

// file: verification/cts_panel_model.sv
// Purpose: operator panel, key and handset facing the sequencer
// Assumes: open lines read high through pull-ups
// Notes: rechannel ground is held well past the debounce time
`timescale 1ns/1ps
`default_nettype none
module cts_panel_model (
   input wire logic clk,
   output logic ptt_n,
   output logic cw_key_n,
   output logic rechannel_request_n,
   output logic [23:0] freq_bcd,
   output logic mode_line,
   output logic power_line
);
   // all switches open at power-up
   initial begin
      ptt_n = 1'b1;
      cw_key_n = 1'b1;
      rechannel_request_n = 1'b1;
      freq_bcd = 24'h020000;
      mode_line = 1'b1;
      power_line = 1'b1;
   end
   task automatic rechan(input logic [23:0] f);
      @(posedge clk);
      freq_bcd <= f;
      rechannel_request_n <= 1'b0;
      repeat (12) @(posedge clk);
      rechannel_request_n <= 1'b1;
   endtask
   // sel high picks the cw key, else ptt
   task automatic key(input bit sel, input bit closed);
      @(posedge clk);
      if (sel) begin
         cw_key_n <= !closed;
      end else begin
         ptt_n <= !closed;
      end
   endtask
   // mode and power switches
   task automatic sw(input bit m, input bit p);
      @(posedge clk);
      mode_line <= m;
      power_line <= p;
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench of the coupler tune sequencer
// Assumes: shortened intervals, 200 MHz clock
// Notes: expected band comes from a bench function, freq and switch expectations from the driven values, the rest are literals
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int HANG = 20, OKC = 10, BAD = 30;
   logic clk, reset_n, synth_locked, bandswitch_done, vswr_high;
   logic tune_overvolt, synth_tone, reg_wr, reg_rd, ptt_n, cw_key_n;
   logic rechannel_request_n, mode_line, power_line, transmit_key;
   logic tx_path_enable, receive_enable, modulator_tone, headset_tone;
   logic servo_enable, synth_rechannel, coupler_rechannel, fault;
   logic am_select, usb_select, high_power_select, low_power_select;
   logic [2:0] band_select;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [23:0] freq_bcd, f;
   logic [7:0] m;
   int fail_count, comparisons, n;
   cts_panel_model pm (.clk(clk), .ptt_n(ptt_n), .cw_key_n(cw_key_n),
      .rechannel_request_n(rechannel_request_n), .freq_bcd(freq_bcd),
      .mode_line(mode_line), .power_line(power_line));
   cts_sequencer #(.HANG_CYC(HANG), .VSWR_OK_CYC(OKC), .VSWR_BAD_CYC(BAD),
      .TUNE_TO_CYC(100), .BEEP_HALF_CYC(4), .DEBOUNCE_CYC(3)) dut (
      .clk(clk), .reset_n(reset_n), .ptt_n(ptt_n), .cw_key_n(cw_key_n),
      .rechannel_request_n(rechannel_request_n), .freq_bcd(freq_bcd),
      .mode_line(mode_line), .power_line(power_line),
      .synth_locked(synth_locked), .bandswitch_done(bandswitch_done),
      .vswr_high(vswr_high), .tune_overvolt(tune_overvolt),
      .synth_tone(synth_tone), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .transmit_key(transmit_key), .tx_path_enable(tx_path_enable),
      .receive_enable(receive_enable), .modulator_tone(modulator_tone),
      .headset_tone(headset_tone), .servo_enable(servo_enable),
      .synth_rechannel(synth_rechannel),
      .coupler_rechannel(coupler_rechannel), .band_select(band_select),
      .fault(fault), .am_select(am_select), .usb_select(usb_select),
      .high_power_select(high_power_select),
      .low_power_select(low_power_select));
   // 5 ns clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // one-cycle strobes; read data stands the cycle after
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return servo_enable;
         1: return transmit_key;
         2: return fault;
         default: return synth_rechannel;
      endcase
   endfunction
   // bounded wait; a timeout shows as a mismatch
   task automatic wt(input int k, input logic v, input int lim);
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge clk) #1 n++;
      end
      chk("wait", sig(k), v);
   endtask
   // band edges in whole MHz
   function automatic logic [2:0] band_of(input int mhz);
      int e[7] = '{3, 4, 6, 8, 11, 15, 21};
      band_of = 3'h0;
      foreach (e[i]) if (mhz >= e[i]) band_of = band_of + 3'h1;
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog, far beyond the expected few hundred cycles
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      {reset_n, reg_wr, reg_rd, vswr_high, tune_overvolt} = 5'h00;
      {synth_locked, bandswitch_done, synth_tone} = 3'h7;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      fail_count = 0;
      comparisons = 0;
      n = $urandom(32'h963cdb47);
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk) #1 chk("rx", receive_enable, 1'b1);
      rd(4'hc);
      chk("unmapped", d, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         pm.sw(i[0], i[1]);
         repeat (3) @(posedge clk);
         #1 chk("am", am_select, !i[0]);
         chk("usb", usb_select, i[0]);
         chk("lo", low_power_select, !i[1]);
         chk("hi", high_power_select, i[1]);
      end
      $display("test switches done");
      // corner bands first, then random frequencies
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 8'd21 : (i == 1) ? 8'd2 : 8'(2 + $urandom % 28);
         f = {4'(m / 10), 4'(m % 10), 12'h000, 4'($urandom % 10)};
         {synth_locked, bandswitch_done} <= 2'b00;
         fork
            pm.rechan(f);
            begin
               wt(3, 1'b1, 30);
               chk("coupler", coupler_rechannel, 1'b1);
            end
         join
         rd(4'h4);
         chk("bandsw", d[2:0], 3'h0);
         chk("txpath", tx_path_enable, 1'b0);
         @(posedge clk);
         {synth_locked, bandswitch_done} <= 2'b11;
         repeat (4) @(posedge clk);
         rd(4'h4);
         chk("standby", d[2:0], 3'h1);
         chk("band", band_select, band_of(m));
         chk("txpath", tx_path_enable, 1'b0);
         rd(4'h8);
         chk("freq", d, f[23:8]);
      end
      $display("test rechannel done");
      pm.key(1'b0, 1'b1);
      pm.key(1'b0, 1'b0);
      repeat (8) @(posedge clk);
      rd(4'h4);
      chk("glitch", d[2:0], 3'h1);
      pm.key(1'b0, 1'b1);
      vswr_high <= 1'b1;
      wt(0, 1'b1, 20);
      chk("key", transmit_key, 1'b1);
      chk("txpath", tx_path_enable, 1'b1);
      chk("hs tone", headset_tone, 1'b1);
      pm.key(1'b0, 1'b0);
      repeat (5) @(posedge clk);
      vswr_high <= 1'b0;
      repeat (5) @(posedge clk);
      // short lapse must restart the good-match count
      vswr_high <= 1'b1;
      @(posedge clk);
      vswr_high <= 1'b0;
      wt(0, 1'b0, 30);
      chk("restart", n >= OKC, 1'b1);
      @(posedge clk) #1 chk("unkey", transmit_key, 1'b0);
      rd(4'h4);
      chk("operate", d[2:0], 3'h3);
      $display("test tune done");
      pm.key(1'b0, 1'b1);
      vswr_high <= 1'b1;
      wt(0, 1'b1, BAD + 20);
      chk("bad span", n >= BAD, 1'b1);
      vswr_high <= 1'b0;
      wt(0, 1'b0, OKC + 10);
      pm.key(1'b0, 1'b0);
      wt(1, 1'b0, 20);
      $display("test retune done");
      wr(4'h0, 16'h0001);
      pm.key(1'b1, 1'b1);
      repeat (8) @(posedge clk);
      #1 chk("cw key", transmit_key, 1'b1);
      chk("modtone", modulator_tone, 1'b1);
      // tone gone from the synthesizer must drop the modulator tone
      synth_tone <= 1'b0;
      @(posedge clk) #1 chk("gate", modulator_tone, 1'b0);
      synth_tone <= 1'b1;
      pm.key(1'b1, 1'b0);
      repeat (HANG / 2) @(posedge clk) #1 chk("hang", transmit_key, 1'b1);
      wt(1, 1'b0, HANG + 10);
      chk("hang end", n + HANG / 2 >= HANG, 1'b1);
      chk("modtone", modulator_tone, 1'b0);
      $display("test cw done");
      wr(4'h0, 16'h0000);
      pm.key(1'b0, 1'b1);
      repeat (8) @(posedge clk);
      tune_overvolt <= 1'b1;
      wt(2, 1'b1, 10);
      tune_overvolt <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("txpath", tx_path_enable, 1'b0);
      chk("servo", servo_enable, 1'b0);
      n = 0;
      repeat (12) @(posedge clk) #1 n += int'(headset_tone);
      chk("beep", n > 0 && n < 12, 1'b1);
      chk("held", fault, 1'b1);
      pm.key(1'b0, 1'b0);
      fork
         pm.rechan(f);
         wt(2, 1'b0, 30);
      join
      $display("test fault done");
      report_and_stop;
   end
endmodule
`default_nettype wire
